// [rtl/adcsq_pkg.sv]
// Function
// RULE1: a falling edge of the serial clock wakes the sequencer from sleep and starts a conversion.
// RULE2: the channel select pins are caught at the starting falling edge and held all conversion.
// RULE3: channel code high then low bit maps 00 to input one, 01 two, 10 three, 11 four.
// RULE4: each further falling edge inside the window (full time / 85.7) drops one bit, six at most.
// RULE5: the host keeps the clock low at least 1 us and high at least 1 us for a reduction edge.
// RULE6: a full resolution conversion (sign plus fifteen bits) lasts nominally 125 ms.
// RULE7: one to six reductions divide that time by 2.0, 4.0, 7.8, 15.1, 28.6 and 51.4.
// RULE8: after the conversion the host pulses the clock and gets one result bit per pulse.
// RULE9: the serial data output is held low for the whole conversion as a busy sign.
// RULE10: after completion each falling edge puts out the next bit, most significant first.
// RULE11: as many bits go out as the chosen resolution, then the sequencer sleeps again.
package adcsq_pkg;

  localparam int unsigned FULL_BITS = 16;
  localparam int unsigned MAX_RED = 6;
  localparam int unsigned CNT_W = 32;

  localparam real CLK_PERIOD_NS = 4.0;
  localparam real FULL_CONV_TIME_MS = 125.0;
  localparam real WINDOW_DIV = 85.7;
  localparam real RED_DIV [0:6] = '{1.0, 2.0, 4.0, 7.8, 15.1, 28.6, 51.4};
  localparam real HOST_MIN_WIDTH_US = 1.0;

  localparam int unsigned FULL_CONV_CYCLES =
    int'($floor(FULL_CONV_TIME_MS * 1.0e6 / CLK_PERIOD_NS));

  localparam logic [2:0] RED_RESET = 3'h0;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic [4:0] BITCNT_RESET = 5'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic DOUT_RESET = 1'b0;

  typedef enum logic [1:0] {
    ADCSQ_SLEEP = 2'b00,
    ADCSQ_CONVERT = 2'b01,
    ADCSQ_DONE = 2'b10
  } adcsq_state_e;

  typedef enum logic [1:0] {
    ADCSQ_IN1 = 2'b00,
    ADCSQ_IN2 = 2'b01,
    ADCSQ_IN3 = 2'b10,
    ADCSQ_IN4 = 2'b11
  } adcsq_chan_e;

  // what the serial-clock domain hands to the core
  typedef struct packed {
    logic toggle;
    adcsq_chan_e chan;
  } adcsq_link_s;

  // nominal times, so rounded down, never below one cycle
  function automatic int unsigned adcsq_cycles(input int unsigned full, input real div);
    int unsigned c;
    c = int'($floor(real'(full) / div));
    return (c < 1) ? 1 : c;
  endfunction : adcsq_cycles

endpackage : adcsq_pkg

// [rtl/adcsq_link.sv]
module adcsq_link (
  // serial clock domain
  input wire logic serialClk,
  input wire logic nrst,
  // channel select pins
  input wire logic channelSelectHigh,
  input wire logic channelSelectLow,
  // toward the core
  output adcsq_pkg::adcsq_link_s linkOut
);

  adcsq_pkg::adcsq_link_s link_q;
  adcsq_pkg::adcsq_link_s link_d;

  // every falling edge flips the toggle and samples the pins with it,
  // so the code is frozen until the next edge, at least 2 us later
  always_comb begin
    link_d.toggle = ~link_q.toggle;
    link_d.chan = adcsq_pkg::adcsq_chan_e'({channelSelectHigh, channelSelectLow}); // [RULE2] [RULE3]
  end

  always_ff @(negedge serialClk or negedge nrst) begin
    if (!nrst) begin
      link_q <= '{toggle: 1'b0, chan: adcsq_pkg::ADCSQ_IN1};
    end else begin
      link_q <= link_d;
    end
  end

  assign linkOut = link_q;

endmodule : adcsq_link

// [rtl/adcsq_timer.sv]
module adcsq_timer (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic clear,
  input wire logic run,
  // status
  output logic [adcsq_pkg::CNT_W-1:0] elapsed
);

  logic [adcsq_pkg::CNT_W-1:0] cnt_q;
  logic [adcsq_pkg::CNT_W-1:0] cnt_d;

  // saturates so a stalled conversion cannot wrap into the window again
  always_comb begin
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = '0;
    end else if (run && (cnt_q != '1)) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign elapsed = cnt_q;

endmodule : adcsq_timer

// [rtl/adcsq_sequencer.sv]
module adcsq_sequencer #(
  parameter int unsigned FULL_CONV_CYCLES = adcsq_pkg::FULL_CONV_CYCLES
) (
  // core clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial link
  input wire logic serialClk,
  input wire logic channelSelectHigh,
  input wire logic channelSelectLow,
  output logic serialResultOut,
  // analog front end
  input wire logic [adcsq_pkg::FULL_BITS-1:0] convResult,
  output logic frontEndOn,
  output logic [1:0] chanSel,
  output logic [4:0] resBits
);

  localparam int unsigned WINDOW_CYCLES =
    adcsq_pkg::adcsq_cycles(FULL_CONV_CYCLES, adcsq_pkg::WINDOW_DIV);

  adcsq_pkg::adcsq_link_s linkData;
  logic [adcsq_pkg::CNT_W-1:0] elapsed;
  logic [adcsq_pkg::CNT_W-1:0] convCyc [0:adcsq_pkg::MAX_RED];

  // conversion length per reduction step
  genvar gi;
  generate
    for (gi = 0; gi <= adcsq_pkg::MAX_RED; gi++) begin : g_len
      assign convCyc[gi] = adcsq_pkg::CNT_W'(adcsq_pkg::adcsq_cycles(
        FULL_CONV_CYCLES, adcsq_pkg::RED_DIV[gi])); // [RULE6] [RULE7]
    end
  endgenerate

  adcsq_link u_link (
    .serialClk(serialClk),
    .nrst(nrst),
    .channelSelectHigh(channelSelectHigh),
    .channelSelectLow(channelSelectLow),
    .linkOut(linkData)
  );

  // toggle crossing; first flop is read only by the second
  logic tglMeta_q;
  logic tglSync_q;
  logic tglPrev_q;
  logic edgeEvt;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tglMeta_q <= 1'b0;
      tglSync_q <= 1'b0;
      tglPrev_q <= 1'b0;
    end else begin
      tglMeta_q <= linkData.toggle;
      tglSync_q <= tglMeta_q;
      tglPrev_q <= tglSync_q;
    end
  end

  assign edgeEvt = tglSync_q ^ tglPrev_q;

  adcsq_pkg::adcsq_state_e state_q;
  adcsq_pkg::adcsq_state_e state_d;
  logic [2:0] red_q;
  logic [2:0] red_d;
  adcsq_pkg::adcsq_chan_e chan_q;
  adcsq_pkg::adcsq_chan_e chan_d;
  logic [adcsq_pkg::FULL_BITS-1:0] result_q;
  logic [adcsq_pkg::FULL_BITS-1:0] result_d;
  logic [4:0] bitCnt_q;
  logic [4:0] bitCnt_d;
  logic dataOut_q;
  logic dataOut_d;
  logic startEvt;
  logic inWindow;
  logic convEnd;

  assign startEvt = (state_q == adcsq_pkg::ADCSQ_SLEEP) && edgeEvt; // [RULE1]
  assign inWindow = elapsed < adcsq_pkg::CNT_W'(WINDOW_CYCLES);
  assign convEnd = elapsed >= convCyc[red_q];

  adcsq_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .clear(startEvt),
    .run(state_q == adcsq_pkg::ADCSQ_CONVERT),
    .elapsed(elapsed)
  );

  always_comb begin
    state_d = state_q;
    red_d = red_q;
    chan_d = chan_q;
    result_d = result_q;
    bitCnt_d = bitCnt_q;
    dataOut_d = dataOut_q;
    case (state_q)
      adcsq_pkg::ADCSQ_SLEEP: begin
        // last bit stays on the line until the next start
        if (edgeEvt) begin
          state_d = adcsq_pkg::ADCSQ_CONVERT; // [RULE1]
          red_d = adcsq_pkg::RED_RESET;
          chan_d = linkData.chan; // [RULE2]
          dataOut_d = 1'b0; // [RULE9]
        end
      end
      adcsq_pkg::ADCSQ_CONVERT: begin
        dataOut_d = 1'b0; // [RULE9]
        // host keeps 1 us widths, so no two edges merge in the crossing
        if (edgeEvt && inWindow && (red_q < 3'(adcsq_pkg::MAX_RED))) begin
          red_d = red_q + 3'h1; // [RULE4] [RULE5]
        end
        if (convEnd) begin
          state_d = adcsq_pkg::ADCSQ_DONE;
          result_d = convResult;
          bitCnt_d = 5'(adcsq_pkg::FULL_BITS) - {2'b00, red_q}; // [RULE11]
          dataOut_d = 1'b1;
        end
      end
      adcsq_pkg::ADCSQ_DONE: begin
        if (edgeEvt) begin
          dataOut_d = result_q[adcsq_pkg::FULL_BITS-1]; // [RULE8] [RULE10]
          result_d = {result_q[adcsq_pkg::FULL_BITS-2:0], 1'b0};
          bitCnt_d = bitCnt_q - 5'h01;
          if (bitCnt_q == 5'h01) begin
            state_d = adcsq_pkg::ADCSQ_SLEEP; // [RULE11]
          end
        end
      end
      default: begin
        state_d = adcsq_pkg::ADCSQ_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= adcsq_pkg::ADCSQ_SLEEP;
      red_q <= adcsq_pkg::RED_RESET;
      chan_q <= adcsq_pkg::ADCSQ_IN1;
      result_q <= adcsq_pkg::RESULT_RESET;
      bitCnt_q <= adcsq_pkg::BITCNT_RESET;
      dataOut_q <= adcsq_pkg::DOUT_RESET;
    end else begin
      state_q <= state_d;
      red_q <= red_d;
      chan_q <= chan_d;
      result_q <= result_d;
      bitCnt_q <= bitCnt_d;
      dataOut_q <= dataOut_d;
    end
  end

  assign serialResultOut = dataOut_q;
  assign frontEndOn = (state_q == adcsq_pkg::ADCSQ_CONVERT);
  assign chanSel = chan_q; // [RULE3]
  assign resBits = 5'(adcsq_pkg::FULL_BITS) - {2'b00, red_q};

endmodule : adcsq_sequencer

// [verif/adcsq_props.sv]
module adcsq_props #(
  parameter int unsigned FULL_CONV_CYCLES = 8570
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial link
  input wire logic serialClk,
  input wire logic channelSelectHigh,
  input wire logic channelSelectLow,
  input wire logic serialResultOut,
  // front end
  input wire logic frontEndOn,
  input wire logic [1:0] chanSel,
  input wire logic [4:0] resBits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic [3:0] since_q;
  int unsigned conv_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b1;
      since_q <= 4'hf;
      conv_q <= 0;
    end else begin
      sclk_q <= serialClk;
      if (sclk_q && !serialClk) since_q <= 4'h0;
      else if (since_q != 4'hf) since_q <= since_q + 4'h1;
      conv_q <= frontEndOn ? conv_q + 1 : 0;
    end
  end
  function automatic int unsigned lenFor(input logic [4:0] r);
    real d [7] = '{1.0, 2.0, 4.0, 7.8, 15.1, 28.6, 51.4};
    return $rtoi(FULL_CONV_CYCLES / d[16 - r]);
  endfunction : lenFor
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // a fall seen through two sync stages lands within a few cycles
  sequence recentFall;
    since_q <= 4'h6;
  endsequence
  chk_start_wake: assert property ($rose(frontEndOn) |-> recentFall)
    else $error("start without fall");
  chk_chan_take: assert property ($rose(frontEndOn) |->
    chanSel == {$past(channelSelectHigh, 4), $past(channelSelectLow, 4)}) else $error("chan");
  chk_chan_hold: assert property (frontEndOn && $past(frontEndOn) |-> $stable(chanSel))
    else $error("chan moved");
  chk_busy_low: assert property (frontEndOn |-> !serialResultOut)
    else $error("busy high");
  chk_res_drop: assert property (frontEndOn && $past(frontEndOn) && $changed(resBits) |->
    (resBits == $past(resBits) - 5'h1 && resBits >= 5'h0a) and recentFall) else $error("res");
  chk_res_idle: assert property (!frontEndOn && !$past(frontEndOn) |-> $stable(resBits))
    else $error("res idle");
  chk_bit_move: assert property ($changed(serialResultOut) |->
    since_q <= 4'h6 || $fell(frontEndOn)) else $error("bit moved");
  chk_conv_len: assert property ($fell(frontEndOn) |->
    conv_q + 2 >= lenFor(resBits) && conv_q <= lenFor(resBits) + 2) else $error("length");
endmodule : adcsq_props

// [verif/adcsq_host.sv]
module adcsq_host (
  // host lines
  output logic serialClk,
  output logic channelSelectHigh,
  output logic channelSelectLow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick = 1'b0;
  realtime tFall;
  initial begin
    serialClk = 1'b1;
    {channelSelectHigh, channelSelectLow} = 2'h0;
    #3.7;
    forever #6 tick = ~tick;
  end
  // clock idles high between frames
  task automatic pulse(input logic [1:0] code);
    @(posedge tick);
    {channelSelectHigh, channelSelectLow} = code;
    @(posedge tick);
    serialClk = 1'b0;
    tFall = $realtime;
    repeat (84) @(posedge tick);
    serialClk = 1'b1;
    {channelSelectHigh, channelSelectLow} = ~code;
    repeat (84) @(posedge tick);
  endtask : pulse
endmodule : adcsq_host

// [verif/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned FULL = 145690;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] convResult = 16'h0000;
  logic serialClk, channelSelectHigh, channelSelectLow, serialResultOut, frontEndOn;
  logic [1:0] chanSel;
  logic [4:0] resBits;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  initial begin
    forever #2 clk = ~clk;
  end
  adcsq_sequencer #(.FULL_CONV_CYCLES(FULL)) DUT (.clk, .nrst, .serialClk, .channelSelectHigh,
    .channelSelectLow, .serialResultOut, .convResult, .frontEndOn, .chanSel, .resBits);
  adcsq_host host (.serialClk, .channelSelectHigh, .channelSelectLow);
  task automatic chk(input logic ok, input string msg);
    compares++;
    // an unknown outcome must count as a mismatch, not slip through
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // start on three codes, then cut each conversion off by reset
  task automatic s_chan();
    for (int c = 0; c < 3; c++) begin
      host.pulse(c[1:0]);
      chk(chanSel === c[1:0], "chan");
      chk(frontEndOn === 1'b1, "no start");
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      chk(resBits === 5'h10, "reset res");
    end
  endtask : s_chan
  task automatic s_conv(input logic [1:0] code, input int nred, input real div,
    input logic [15:0] word);
    realtime t0;
    int n;
    @(posedge clk);
    convResult <= word;
    host.pulse(code);
    t0 = host.tFall;
    chk(chanSel === code && serialResultOut === 1'b0, "start");
    repeat (nred) host.pulse(code);
    // this fall comes after the window and must be ignored
    #3000 host.pulse(code);
    chk(resBits === 5'(16 - nred), "res");
    n = 0;
    while (serialResultOut !== 1'b1 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    n = $rtoi(($realtime - t0) / 4.0);
    chk(n >= $rtoi(FULL / div) && n <= $rtoi(FULL / div) + 10, "time");
    for (int i = 15; i >= nred; i--) begin
      host.pulse(code);
      chk(serialResultOut === word[i], "bit");
    end
    chk(frontEndOn === 1'b0 && resBits === 5'(16 - nred), "end");
  endtask : s_conv
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    s_chan();
    s_conv(2'h3, 3, 7.8, 16'hb5a3);
    s_conv(2'h1, 2, 4.0, 16'h6c3d);
    close_out();
  end
endmodule : testbench

bind adcsq_sequencer adcsq_props #(.FULL_CONV_CYCLES(FULL_CONV_CYCLES)) props (.clk, .nrst,
  .serialClk, .channelSelectHigh, .channelSelectLow, .serialResultOut, .frontEndOn, .chanSel,
  .resBits);
